//--- axis_gain_trim_registers.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - three unsigned nine-bit gain trims, one per axis
// - x gain low at 0x30, msb 0x2b bit7
// - y gain low at 0x31, msb 0x2d bit7
// - z gain low at 0x32, msb 0x2f bit7
// - offset field is signed fifteen-bit value
// - reset loads per-chip factory calibration values
module axis_gain_trim_registers #(
  parameter logic [8:0] X_SCALE_FACTORY = 9'h100,
  parameter logic [8:0] Y_SCALE_FACTORY = 9'h100,
  parameter logic [8:0] Z_SCALE_FACTORY = 9'h100,
  parameter logic [14:0] X_ZERO_FACTORY = 15'h0000,
  parameter logic [14:0] Y_ZERO_FACTORY = 15'h0000,
  parameter logic [14:0] Z_ZERO_FACTORY = 15'h0000
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic sample_valid_in,
  input wire logic [15:0] x_raw_in,
  input wire logic [15:0] y_raw_in,
  input wire logic [15:0] z_raw_in,
  output logic [15:0] x_result_out,
  output logic [15:0] y_result_out,
  output logic [15:0] z_result_out,
  output logic [8:0] x_scale_trim_out,
  output logic [8:0] y_scale_trim_out,
  output logic [8:0] z_scale_trim_out,
  output logic [14:0] x_zero_trim_out,
  output logic [14:0] y_zero_trim_out,
  output logic [14:0] z_zero_trim_out
);
  localparam logic [8:0] SCALE_FACTORY [3] = '{X_SCALE_FACTORY, Y_SCALE_FACTORY,
                                              Z_SCALE_FACTORY};
  localparam logic [14:0] ZERO_FACTORY [3] = '{X_ZERO_FACTORY, Y_ZERO_FACTORY,
                                              Z_ZERO_FACTORY};
  localparam logic [7:0] LOW_ZERO_ADDR [3] = '{trim_pkg::X_ZERO_LOW_ADDR,
                                              trim_pkg::Y_ZERO_LOW_ADDR, trim_pkg::Z_ZERO_LOW_ADDR};
  localparam logic [7:0] UPPER_ADDR [3] = '{trim_pkg::X_ZERO_UPPER_ADDR,
                                           trim_pkg::Y_ZERO_UPPER_ADDR, trim_pkg::Z_ZERO_UPPER_ADDR};
  localparam logic [7:0] SCALE_ADDR [3] = '{trim_pkg::X_SCALE_LOW_ADDR,
                                           trim_pkg::Y_SCALE_LOW_ADDR, trim_pkg::Z_SCALE_LOW_ADDR};

  logic [8:0] scale_r [3];
  logic [14:0] zero_r [3];
  logic [15:0] raw [3];
  logic [15:0] result [3];
  trim_load_if trim_bus [3] ();

  // address match helper
  function automatic logic hit(input logic en, input logic [7:0] a, input logic [7:0] b);
    hit = en && (a == b);
  endfunction

  assign raw[0] = x_raw_in;
  assign raw[1] = y_raw_in;
  assign raw[2] = z_raw_in;

  ////////////////////////////////////////////////////////////////////////////
  // per-axis trim storage and datapath
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : axis
      logic wr_upper;
      logic wr_zero_low;
      logic wr_scale_low;
      logic [8:0] scale_nxt;
      logic [14:0] zero_nxt;

      // decode writes for this axis
      assign wr_upper = hit(wr_en_in, wr_addr_in, UPPER_ADDR[g]);
      assign wr_zero_low = hit(wr_en_in, wr_addr_in, LOW_ZERO_ADDR[g]);
      assign wr_scale_low = hit(wr_en_in, wr_addr_in, SCALE_ADDR[g]);

      // whole byte written; host keeps neighbours via a shadow copy of the upper byte
      assign scale_nxt = {wr_upper ? wr_data_in[trim_pkg::UPPER_SCALE_BIT] : scale_r[g][8],
                          wr_scale_low ? wr_data_in : scale_r[g][7:0]};
      assign zero_nxt = {wr_upper ? wr_data_in[trim_pkg::UPPER_ZERO_MSB:0] : zero_r[g][14:8],
                         wr_zero_low ? wr_data_in : zero_r[g][7:0]};

      // factory values at reset, host may overwrite
      always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          scale_r[g] <= SCALE_FACTORY[g];
          zero_r[g] <= ZERO_FACTORY[g];
        end else begin
          scale_r[g] <= scale_nxt;
          zero_r[g] <= zero_nxt;
        end
      end

      assign trim_bus[g].load = sample_valid_in;
      assign trim_bus[g].scale = scale_r[g];
      assign trim_bus[g].zero = zero_r[g];

      // gain and offset applied before readout
      axis_trim_apply u_apply (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .valid_in(trim_bus[g].load),
        .raw_in(raw[g]),
        .scale_in(trim_bus[g].scale),
        .zero_in(trim_bus[g].zero),
        .result_out(result[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign x_result_out = result[0];
  assign y_result_out = result[1];
  assign z_result_out = result[2];
  assign x_scale_trim_out = scale_r[0];
  assign y_scale_trim_out = scale_r[1];
  assign z_scale_trim_out = scale_r[2];
  assign x_zero_trim_out = zero_r[0];
  assign y_zero_trim_out = zero_r[1];
  assign z_zero_trim_out = zero_r[2];
endmodule
`default_nettype wire

//--- axis_gain_trim_registers_props.sv
`timescale 1ns/1ps
`default_nettype none
module agtr_props (
  input wire logic clk_in, sys_rst_in, wr_en_in, sample_valid_in,
  input wire logic [7:0] wr_addr_in, wr_data_in,
  input wire logic [15:0] z_raw_in, z_result_out,
  input wire logic [8:0] x_scale_trim_out, y_scale_trim_out, z_scale_trim_out,
  input wire logic [14:0] x_zero_trim_out, y_zero_trim_out, z_zero_trim_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // strobe with address, and data of the previous edge
  wire logic [8:0] w = {wr_en_in, wr_addr_in};
  logic [7:0] dq;
  always_ff @(posedge clk_in) dq <= wr_data_in;
  property p_xl; w == 9'h130 |=> x_scale_trim_out[7:0] == dq; endproperty
  a_xl: assert property (p_xl) else $error("x low");
  property p_xu; w == 9'h12b |=> {x_scale_trim_out[8], x_zero_trim_out[14:8]} == dq; endproperty
  a_xu: assert property (p_xu) else $error("x upper");
  property p_yl; w == 9'h131 |=> y_scale_trim_out[7:0] == dq; endproperty
  a_yl: assert property (p_yl) else $error("y low");
  property p_yu; w == 9'h12d |=> {y_scale_trim_out[8], y_zero_trim_out[14:8]} == dq; endproperty
  a_yu: assert property (p_yu) else $error("y upper");
  property p_zl; w == 9'h132 |=> z_scale_trim_out[7:0] == dq; endproperty
  a_zl: assert property (p_zl) else $error("z low");
  property p_zu; w == 9'h12f |=> {z_scale_trim_out[8], z_zero_trim_out[14:8]} == dq; endproperty
  a_zu: assert property (p_zu) else $error("z upper");
  property p_hold; !wr_en_in |=> $stable({x_scale_trim_out, y_scale_trim_out, z_scale_trim_out});
  endproperty
  a_hold: assert property (p_hold) else $error("trim moved");
  property p_unity; sample_valid_in && z_scale_trim_out == 9'h100 && z_zero_trim_out == 0
    |=> z_result_out == $past(z_raw_in); endproperty
  a_unity: assert property (p_unity) else $error("unity gain");
endmodule
bind axis_gain_trim_registers agtr_props u_props (.*);
`default_nettype wire

//--- axis_gain_trim_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module axis_gain_trim_registers_tb;
  logic clk_in = 0, sys_rst_in = 1, wr_en, sv = 0;
  logic [7:0] wa, wd;
  logic [15:0] raw [3], res [3];
  logic [8:0] sc [3];
  logic [14:0] zr [3];
  int g [3] = '{'h0f3, 'h1a5, 'h100}, z [3] = '{'h7001, 'h0123, 0};
  int miscompares = 0, checked = 0, ax;
  always #20 clk_in = ~clk_in;
  trim_host host (.clk_in(clk_in), .wr_en_out(wr_en), .wr_addr_out(wa), .wr_data_out(wd));
  axis_gain_trim_registers #(.X_SCALE_FACTORY(9'h0f3), .Y_SCALE_FACTORY(9'h1a5),
    .X_ZERO_FACTORY(15'h7001), .Y_ZERO_FACTORY(15'h0123)) DUT (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .wr_en_in(wr_en), .wr_addr_in(wa), .wr_data_in(wd),
    .sample_valid_in(sv), .x_raw_in(raw[0]), .y_raw_in(raw[1]), .z_raw_in(raw[2]),
    .x_result_out(res[0]), .y_result_out(res[1]), .z_result_out(res[2]),
    .x_scale_trim_out(sc[0]), .y_scale_trim_out(sc[1]), .z_scale_trim_out(sc[2]),
    .x_zero_trim_out(zr[0]), .y_zero_trim_out(zr[1]), .z_zero_trim_out(zr[2]));
  // model: scale by trim over 256, add signed offset, saturate
  function automatic logic [15:0] calc(int i);
    int r;
    r = (($signed(raw[i]) * g[i]) >>> 8) + (z[i] >= 16384 ? z[i] - 32768 : z[i]);
    return 16'(r > 32767 ? 32767 : r < -32768 ? -32768 : r);
  endfunction
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic sample;
    @(negedge clk_in);
    sv = 1;
    foreach (raw[i]) raw[i] = 16'($urandom);
    @(negedge clk_in);
    sv = 0;
    foreach (raw[i]) begin
      chk("scale", 16'(sc[i]), 16'(g[i]));
      chk("zero", 16'(zr[i]), 16'(z[i]));
      chk("result", res[i], calc(i));
    end
  endtask
  task automatic conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h7762));
    foreach (raw[i]) raw[i] = 16'h0000;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in) sys_rst_in = 0;
    sample;
    repeat (12) begin
      ax = $urandom_range(2);
      g[ax] = $urandom_range(511);
      z[ax] = $urandom_range(32767);
      host.set_zero(ax, 15'(z[ax]));
      host.set_scale(ax, 9'(g[ax]));
      host.wr(8'(8'h33 + $urandom_range(200)), 8'($urandom));
      sample;
    end
    // mid-run reset brings factory trims back
    @(negedge clk_in) sys_rst_in = 1;
    @(negedge clk_in);
    foreach (res[i]) chk("reset result", res[i], 16'h0000);
    @(negedge clk_in) sys_rst_in = 0;
    g = '{'h0f3, 'h1a5, 'h100};
    z = '{'h7001, 'h0123, 0};
    host.upper = '{8'h70, 8'h81, 8'h80};
    sample;
    conclude;
  end
  // watchdog
  initial begin
    #500us;
    miscompares++;
    conclude;
  end
endmodule
`default_nettype wire

//--- axis_trim_apply.sv
`timescale 1ns/1ps
`default_nettype none
module axis_trim_apply (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic valid_in,
  input wire logic signed [15:0] raw_in,
  input wire logic [8:0] scale_in,
  input wire logic signed [14:0] zero_in,
  output logic signed [15:0] result_out
);
  logic signed [26:0] prod;
  logic signed [26:0] shifted;
  logic signed [27:0] sum;
  logic signed [15:0] sat;

  // gain multiply, unity at 256, then offset add and saturate
  assign prod = 27'(raw_in * $signed({1'b0, scale_in}));
  assign shifted = prod >>> trim_pkg::SCALE_FRAC_W;
  assign sum = 28'(shifted) + 28'(zero_in);
  assign sat = (sum > 28'sh0007fff) ? 16'sh7fff :
               (sum < -28'sh0008000) ? -16'sh8000 : 16'(sum);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      result_out <= 16'sh0000;
    end else if (valid_in) begin
      result_out <= sat;
    end
  end
endmodule
`default_nettype wire

//--- trim_host.sv
`timescale 1ns/1ps
`default_nettype none
module trim_host (
  input wire logic clk_in,
  output logic wr_en_out,
  output logic [7:0] wr_addr_out,
  output logic [7:0] wr_data_out
);
  // shadow of upper bytes, registers are write-only
  logic [7:0] upper [3] = '{8'h70, 8'h81, 8'h80};
  initial begin
    wr_en_out = 0;
    wr_addr_out = 8'h00;
    wr_data_out = 8'h00;
  end
  // one byte write, bus scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    {wr_en_out, wr_addr_out, wr_data_out} = {1'b1, a, d};
    @(negedge clk_in);
    {wr_en_out, wr_addr_out, wr_data_out} = {1'b0, ~a, ~d};
  endtask
  // merge into shadow so the neighbour field survives
  task automatic set_scale(input int ax, input logic [8:0] g);
    upper[ax][7] = g[8];
    wr(8'(8'h2b + 2 * ax), upper[ax]);
    wr(8'(8'h30 + ax), g[7:0]);
  endtask
  task automatic set_zero(input int ax, input logic [14:0] o);
    upper[ax][6:0] = o[14:8];
    wr(8'(8'h2a + 2 * ax), o[7:0]);
    wr(8'(8'h2b + 2 * ax), upper[ax]);
  endtask
endmodule
`default_nettype wire

//--- trim_load_if.sv
`timescale 1ns/1ps
`default_nettype none
interface trim_load_if;
  logic load;
  logic [8:0] scale;
  logic [14:0] zero;
  modport src (output load, scale, zero);
  modport dst (input load, scale, zero);
endinterface
`default_nettype wire

//--- trim_pkg.sv
package trim_pkg;
  localparam int unsigned NUM_AXES = 3;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SCALE_W = 9;
  localparam int unsigned ZERO_W = 15;
  localparam int unsigned SAMPLE_W = 16;
  // register offsets
  localparam logic [7:0] X_ZERO_LOW_ADDR = 8'h2a;
  localparam logic [7:0] X_ZERO_UPPER_ADDR = 8'h2b;
  localparam logic [7:0] Y_ZERO_LOW_ADDR = 8'h2c;
  localparam logic [7:0] Y_ZERO_UPPER_ADDR = 8'h2d;
  localparam logic [7:0] Z_ZERO_LOW_ADDR = 8'h2e;
  localparam logic [7:0] Z_ZERO_UPPER_ADDR = 8'h2f;
  localparam logic [7:0] X_SCALE_LOW_ADDR = 8'h30;
  localparam logic [7:0] Y_SCALE_LOW_ADDR = 8'h31;
  localparam logic [7:0] Z_SCALE_LOW_ADDR = 8'h32;
  // field positions within the upper register
  localparam int unsigned UPPER_SCALE_BIT = 7;
  localparam int unsigned UPPER_ZERO_MSB = 6;
  // unity gain: trim of 256 means a factor of one
  localparam int unsigned SCALE_FRAC_W = 8;
endpackage
